// File: hw/lbe_err_counter.sv
// Forward-link error counter with loss-of-lock threshold
// Assumes a clock that is the recovered pixel clock and synchronous inputs
`timescale 1ns/100ps
module lbe_err_counter
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic relock_i,
  lbe_err_if.counter err
);
  typedef struct packed
  {
    logic [3:0] count;
    logic       lost;
  } lbe_cnt_state_type;

  lbe_cnt_state_type state_q;
  lbe_cnt_state_type state_d;
  logic              hit;
  logic [3:0]        next_count;

  // Error detection over both clock bits, parity and control bit
  always_comb
  begin
    hit        = (|err.err_bits) && !(err.filter_wait && err.filter_wait_mask);
    next_count = state_q.count + 4'h1;
    state_d    = state_q;
    if (relock_i)
    begin
      state_d = '0;
    end
    else if (hit && !state_q.lost)
    begin
      if (!err.count_en)
      begin
        state_d.lost = 1'b1;
      end
      else
      begin
        state_d.count = next_count;
        if (next_count >= err.threshold)
        begin
          state_d.lost = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign err.lock_lost = state_q.lost;
  assign err.count     = state_q.count;
endmodule

// File: hw/lbe_err_if.sv
// Interface between the register bank and the link error counter
// Assumes both ends run on the same recovered pixel clock
`timescale 1ns/100ps
interface lbe_err_if;
  logic       count_en;
  logic       filter_wait_mask;
  logic [3:0] threshold;
  logic       filter_wait;
  logic [3:0] err_bits;
  logic       lock_lost;
  logic [3:0] count;
  modport ctrl
  (
    output count_en,
    output filter_wait_mask,
    output threshold,
    output filter_wait,
    output err_bits,
    input  lock_lost,
    input  count
  );
  modport counter
  (
    input  count_en,
    input  filter_wait_mask,
    input  threshold,
    input  filter_wait,
    input  err_bits,
    output lock_lost,
    output count
  );
endinterface

// File: hw/lbe_pkg.sv
// Package for the link self-test and error control register bank
// Assumes 8-bit register offsets reached by the device's own register port
package lbe_pkg;
  // Register offsets
  localparam logic [7:0] OFS_SELF_TEST_CONTROL    = 8'hb3;
  localparam logic [7:0] OFS_RESERVED_B4          = 8'hb4;
  localparam logic [7:0] OFS_RESERVED_B5          = 8'hb5;
  localparam logic [7:0] OFS_RESERVED_B6          = 8'hb6;
  localparam logic [7:0] OFS_RESERVED_B7          = 8'hb7;
  localparam logic [7:0] OFS_STRAP_DECODE_STATUS  = 8'hb8;
  localparam logic [7:0] OFS_LINK_ERR_CTRL        = 8'hb9;
  localparam logic [7:0] OFS_LINK_ENCODER_CONTROL = 8'hba;
  // Offset of the clock source register in the remote serializer
  localparam logic [7:0] OFS_REMOTE_CLOCK_SOURCE  = 8'h14;
  // Reset values
  localparam logic [7:0] RST_SELF_TEST_CONTROL    = 8'h08;
  localparam logic [7:0] RST_RESERVED_B4          = 8'h25;
  localparam logic [7:0] RST_RESERVED_B5          = 8'h00;
  localparam logic [7:0] RST_RESERVED_B6          = 8'h18;
  localparam logic [7:0] RST_RESERVED_B7          = 8'h00;
  localparam logic [7:0] RST_LINK_ERR_CTRL        = 8'h33;
  localparam logic [7:0] RST_LINK_ENCODER_CONTROL = 8'h83;
  // Self-test control fields
  localparam int POS_OUT_MODE_HI = 7;
  localparam int POS_OUT_MODE_LO = 6;
  localparam int POS_CFG_SEL     = 3;
  localparam int POS_CLK_SRC_HI  = 2;
  localparam int POS_CLK_SRC_LO  = 1;
  localparam int POS_TEST_EN     = 0;
  localparam logic [7:0] MSK_SELF_TEST_WR = 8'hcf;
  // Strap status fields
  localparam int POS_INDEX_STRAP_DONE  = 7;
  localparam int POS_MODE_DONE = 3;
  // Link error control fields
  localparam int POS_FILTER_WAIT_MASK = 5;
  localparam int POS_ERR_COUNT_EN     = 4;
  localparam logic [7:0] MSK_LINK_ERR_WR = 8'h3f;
  // Encoder control field
  localparam int POS_ENC_CRC_DIS = 7;
  localparam logic [7:0] MSK_ENCODER_WR = 8'h80;
  // Strap decode latency after reset release, in cycles
  localparam logic [3:0] STRAP_SETTLE_CYCLES = 4'h8;
  // Output modes of self test
  typedef enum logic [1:0]
  {
    OUT_NONE = 2'b00,
    OUT_ALT  = 2'b01
  } lbe_out_mode_type;
endpackage

// File: hw/lbe_top.sv
// Shared control and status bank: self test, strap status, link errors, encoder CRC
// Assumes a synchronous register port and that the clock is the recovered pixel clock
// Behaviour
// - Output mode 00 gives no toggling, 01 alternates one and zero, 1x follows test data.
// - With configuration bit 3 clear the low three bits configure self test; set is reserved and the default.
// - The two clock source bits are copied to the remote serializer's register 0x14.
// - That copy is made after self test is enabled by its enable bit.
// - Bit 7 of strap status shows the index strap decode has finished and latched.
// - Bits 6 to 4 of strap status show the decoded index strap value.
// - Bit 3 of strap status shows the mode strap decode has finished and latched.
// - Bits 2 to 0 of strap status show the decoded mode strap value.
// - With bit 5 set errors during the adaptive filter wait are ignored, else they count.
// - Bit 4 enables the link error counter.
// - With the counter enabled, lock drops when the count reaches the threshold field.
// - With the counter disabled, lock drops on the first error.
// - Encoder control bit 7 at 0 enables encoder CRC, at 1 disables it, reset 1.
`timescale 1ns/100ps
module lbe_top
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic [2:0] INDEX_STRAP_I,
  input  wire logic [2:0] MODE_STRAP_I,
  input  wire logic [3:0] LINK_ERR_BITS_I,
  input  wire logic       FILTER_WAIT_I,
  input  wire logic       RELOCK_I,
  input  wire logic       TEST_DATA_I,
  input  wire logic       REMOTE_WR_DONE_I,
  output logic [7:0]      REG_RDATA_O,
  output logic            REG_RVALID_O,
  output logic            TEST_OUT_O,
  output logic            TEST_EN_O,
  output logic            TEST_CFG_LOCAL_O,
  output logic            REMOTE_WR_O,
  output logic [7:0]      REMOTE_ADDR_O,
  output logic [1:0]      REMOTE_DATA_O,
  output logic            LOCK_O,
  output logic            ENC_CRC_EN_O
);
  typedef struct packed
  {
    logic [7:0] self_test;
    logic [7:0] link_err;
    logic [7:0] encoder;
    logic [2:0] idx_val;
    logic [2:0] mode_val;
    logic       index_strap_done;
    logic       mode_done;
    logic [3:0] settle;
    logic [7:0] rdata;
    logic       rvalid;
    logic       test_out;
    logic       test_en;
    logic       cfg_local;
    logic       remote_wr;
    logic       remote_pend;
    logic [1:0] remote_data;
    logic       lock;
    logic       crc_en;
  } lbe_state_type;

  lbe_state_type state_q;
  lbe_state_type state_d;
  lbe_err_if     err_bus ();
  logic [7:0]    strap_status;

  // Read decoding, shared by the read path
  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input lbe_state_type s,
                                          input logic [7:0] sts);
    case (addr)
      lbe_pkg::OFS_SELF_TEST_CONTROL:    read_reg = s.self_test;
      lbe_pkg::OFS_RESERVED_B4:          read_reg = lbe_pkg::RST_RESERVED_B4;
      lbe_pkg::OFS_RESERVED_B5:          read_reg = lbe_pkg::RST_RESERVED_B5;
      lbe_pkg::OFS_RESERVED_B6:          read_reg = lbe_pkg::RST_RESERVED_B6;
      lbe_pkg::OFS_RESERVED_B7:          read_reg = lbe_pkg::RST_RESERVED_B7;
      lbe_pkg::OFS_STRAP_DECODE_STATUS:  read_reg = sts;
      lbe_pkg::OFS_LINK_ERR_CTRL:        read_reg = s.link_err;
      lbe_pkg::OFS_LINK_ENCODER_CONTROL: read_reg = s.encoder;
      default:                           read_reg = 8'h00;
    endcase
  endfunction

  // Strap status word
  assign strap_status = {state_q.index_strap_done, state_q.idx_val,
                         state_q.mode_done, state_q.mode_val};

  // Fields handed to the error counter
  assign err_bus.count_en         = state_q.link_err[lbe_pkg::POS_ERR_COUNT_EN];
  assign err_bus.filter_wait_mask = state_q.link_err[lbe_pkg::POS_FILTER_WAIT_MASK];
  assign err_bus.threshold        = state_q.link_err[3:0];
  assign err_bus.filter_wait      = FILTER_WAIT_I;
  assign err_bus.err_bits         = LINK_ERR_BITS_I;

  // Error counter on the pixel clock
  lbe_err_counter u_err
  (
    .clk_i    (CLK_SYS_I),
    .rst_i    (RST_I),
    .relock_i (RELOCK_I),
    .err      (err_bus)
  );

  // Next state of the bank
  always_comb
  begin
    state_d           = state_q;
    state_d.rvalid    = REG_RD_I;
    state_d.remote_wr = 1'b0;
    if (REG_RD_I)
    begin
      state_d.rdata = read_reg(REG_ADDR_I, state_q, strap_status);
    end
    // Register writes; reserved bits keep defaults
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        lbe_pkg::OFS_SELF_TEST_CONTROL:
        begin
          state_d.self_test = (REG_WDATA_I & lbe_pkg::MSK_SELF_TEST_WR)
                            | (lbe_pkg::RST_SELF_TEST_CONTROL & ~lbe_pkg::MSK_SELF_TEST_WR);
          // Rising enable schedules the clock source copy
          if (REG_WDATA_I[lbe_pkg::POS_TEST_EN] && !state_q.self_test[lbe_pkg::POS_TEST_EN])
          begin
            state_d.remote_pend = 1'b1;
          end
        end
        lbe_pkg::OFS_LINK_ERR_CTRL:
        begin
          state_d.link_err = REG_WDATA_I & lbe_pkg::MSK_LINK_ERR_WR;
        end
        lbe_pkg::OFS_LINK_ENCODER_CONTROL:
        begin
          state_d.encoder = (REG_WDATA_I & lbe_pkg::MSK_ENCODER_WR)
                          | (lbe_pkg::RST_LINK_ENCODER_CONTROL & ~lbe_pkg::MSK_ENCODER_WR);
        end
        default:
        begin
          state_d.rdata = state_d.rdata;
        end
      endcase
    end
    // Strap decode completes a fixed time after reset release
    if (!state_q.index_strap_done)
    begin
      if (state_q.settle == lbe_pkg::STRAP_SETTLE_CYCLES)
      begin
        state_d.idx_val   = INDEX_STRAP_I;
        state_d.mode_val  = MODE_STRAP_I;
        state_d.index_strap_done  = 1'b1;
        state_d.mode_done = 1'b1;
      end
      else
      begin
        state_d.settle = state_q.settle + 4'h1;
      end
    end
    // Copy clock source to the serializer once enabled
    if (state_q.remote_pend && state_q.test_en)
    begin
      state_d.remote_wr   = 1'b1;
      state_d.remote_data = state_q.self_test[lbe_pkg::POS_CLK_SRC_HI:lbe_pkg::POS_CLK_SRC_LO];
      if (REMOTE_WR_DONE_I)
      begin
        state_d.remote_pend = 1'b0;
        state_d.remote_wr   = 1'b0;
      end
    end
    if (!state_d.self_test[lbe_pkg::POS_TEST_EN])
    begin
      state_d.remote_pend = 1'b0;
    end
    // Self-test output and configuration
    state_d.test_en   = state_q.self_test[lbe_pkg::POS_TEST_EN];
    state_d.cfg_local = !state_q.self_test[lbe_pkg::POS_CFG_SEL];
    case (state_q.self_test[lbe_pkg::POS_OUT_MODE_HI:lbe_pkg::POS_OUT_MODE_LO])
      lbe_pkg::OUT_NONE: state_d.test_out = 1'b0;
      lbe_pkg::OUT_ALT:  state_d.test_out = !state_q.test_out;
      default:           state_d.test_out = TEST_DATA_I;
    endcase
    state_d.lock   = !err_bus.lock_lost;
    state_d.crc_en = !state_q.encoder[lbe_pkg::POS_ENC_CRC_DIS];
  end

  // State register
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      state_q           <= '0;
      state_q.self_test <= lbe_pkg::RST_SELF_TEST_CONTROL;
      state_q.link_err  <= lbe_pkg::RST_LINK_ERR_CTRL;
      state_q.encoder   <= lbe_pkg::RST_LINK_ENCODER_CONTROL;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops, except the constant remote address
  assign REG_RDATA_O      = state_q.rdata;
  assign REG_RVALID_O     = state_q.rvalid;
  assign TEST_OUT_O       = state_q.test_out;
  assign TEST_EN_O        = state_q.test_en;
  assign TEST_CFG_LOCAL_O = state_q.cfg_local;
  assign REMOTE_WR_O      = state_q.remote_wr;
  assign REMOTE_ADDR_O    = lbe_pkg::OFS_REMOTE_CLOCK_SOURCE;
  assign REMOTE_DATA_O    = state_q.remote_data;
  assign LOCK_O           = state_q.lock;
  assign ENC_CRC_EN_O     = state_q.crc_en;
endmodule

// File: tb/lbe_ser_model.sv
// Remote serializer model: accepts clock source writes and acknowledges them
// Assumes requests are held until acknowledged, all on the rising edge
`timescale 1ns/100ps
module lbe_ser_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       slow_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [1:0] data_i,
  output logic            done_o,
  output logic [1:0]      clk_src_o
);
  logic [3:0] wait_q;
  // Acknowledge after one cycle, or ten when slow; keep only the clock source register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clk_src_o <= 2'h0;
    if (rst_i || done_o || !wr_i)
    begin
      done_o <= 1'b0;
      wait_q <= 4'h0;
    end
    else if (wait_q >= (slow_i ? 4'ha : 4'h1))
    begin
      done_o <= addr_i == 8'h14;
      if (addr_i == 8'h14)
        clk_src_o <= data_i;
    end
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule

// File: tb/lbe_top_asserts.sv
// Checker for the self-test and link error bank, on top ports only
// Assumes one clock with synchronous active-high reset
`timescale 1ns/100ps
module lbe_top_asserts
(
  input wire logic       CLK_SYS_I,
  input wire logic       RST_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [3:0] LINK_ERR_BITS_I,
  input wire logic       RELOCK_I,
  input wire logic       REMOTE_WR_DONE_I,
  input wire logic       REG_RVALID_O,
  input wire logic       TEST_EN_O,
  input wire logic       TEST_CFG_LOCAL_O,
  input wire logic       REMOTE_WR_O,
  input wire logic [7:0] REMOTE_ADDR_O,
  input wire logic [1:0] REMOTE_DATA_O,
  input wire logic       LOCK_O
);
  logic [1:0] up_q;
  // Cycles since reset, so lock checks skip the power-up rise
  always_ff @(posedge CLK_SYS_I)
    up_q <= RST_I ? 2'h0 : (up_q == 2'h3 ? up_q : up_q + 2'h1);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Register port answers
  a_read_answer: assert property (REG_RD_I |=> REG_RVALID_O)
    else $error("read without answer");
  a_rvalid_cause: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("answer without read");
  // Clock source copy to the serializer
  a_copy_start: assert property (REG_WR_I && REG_ADDR_I == 8'hb3 && REG_WDATA_I[0] && !TEST_EN_O
    |-> ##3 REMOTE_WR_O && REMOTE_ADDR_O == 8'h14 && REMOTE_DATA_O == $past(REG_WDATA_I[2:1], 3))
    else $error("copy not started");
  a_copy_needs_en: assert property ($rose(REMOTE_WR_O) |-> TEST_EN_O)
    else $error("copy without enable");
  a_copy_hold: assert property (REMOTE_WR_O && !REMOTE_WR_DONE_I && TEST_EN_O
    && !(REG_WR_I && REG_ADDR_I == 8'hb3) |=> REMOTE_WR_O)
    else $error("copy request dropped");
  a_copy_end: assert property (REMOTE_WR_O && REMOTE_WR_DONE_I |=> !REMOTE_WR_O)
    else $error("copy request not released");
  a_cfg_local: assert property (REG_WR_I && REG_ADDR_I == 8'hb3 && !REG_WDATA_I[3]
    |-> ##[1:2] TEST_CFG_LOCAL_O)
    else $error("local config not shown");
  // Loss of lock
  a_lock_holds: assert property (up_q == 2'h3 && !LOCK_O && !RELOCK_I && !$past(RELOCK_I)
    && !$past(RELOCK_I, 2) |=> !LOCK_O)
    else $error("lock regained without relock");
  a_drop_cause: assert property ($fell(LOCK_O)
    |-> $past(LINK_ERR_BITS_I) != 4'h0 || $past(LINK_ERR_BITS_I, 2) != 4'h0)
    else $error("lock lost without error");
  c_copy: cover property ($rose(REMOTE_WR_O));
  c_drop: cover property ($fell(LOCK_O));
  c_read: cover property (REG_RVALID_O);
endmodule
bind lbe_top lbe_top_asserts i_chk (.CLK_SYS_I, .RST_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I,
  .REG_WDATA_I, .LINK_ERR_BITS_I, .RELOCK_I, .REMOTE_WR_DONE_I, .REG_RVALID_O, .TEST_EN_O,
  .TEST_CFG_LOCAL_O, .REMOTE_WR_O, .REMOTE_ADDR_O, .REMOTE_DATA_O, .LOCK_O);

// File: tb/testbench.sv
// Bench for the self-test and link error bank: register tasks and scenarios
// Assumes the serializer model on the copy port and a 50 ns clock
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, fwait = 1'b0;
  logic        relock = 1'b0, tdata = 1'b0, slow = 1'b0, v;
  logic        done, rvalid, tout, ten, tloc, rwr, lock, crc;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, raddr;
  logic [3:0]  errb = 4'h0;
  logic [2:0]  idx_s = 3'h5, mode_s = 3'h2;
  logic [1:0]  rdat, src;
  int          error_cnt = 0, checked = 0;
  logic [15:0] rst_tab [7] = '{16'hb308, 16'hb425, 16'hb500, 16'hb618, 16'hb700, 16'hb933,
                               16'hba83};
  // Device and serializer model
  lbe_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .INDEX_STRAP_I(idx_s), .MODE_STRAP_I(mode_s), .LINK_ERR_BITS_I(errb),
    .FILTER_WAIT_I(fwait), .RELOCK_I(relock), .TEST_DATA_I(tdata), .REMOTE_WR_DONE_I(done),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .TEST_OUT_O(tout), .TEST_EN_O(ten),
    .TEST_CFG_LOCAL_O(tloc), .REMOTE_WR_O(rwr), .REMOTE_ADDR_O(raddr), .REMOTE_DATA_O(rdat),
    .LOCK_O(lock), .ENC_CRC_EN_O(crc));
  lbe_ser_model i_ser (.clk_i(clk), .rst_i(rst), .slow_i(slow), .wr_i(rwr), .addr_i(raddr),
    .data_i(rdat), .done_o(done), .clk_src_o(src));
  // Clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  // Comparison and verdict
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Register port cycles, driven on the falling edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    chk("read valid", {7'h0, rvalid}, 8'h01);
    chk(n, rdata, e);
  endtask
  // Bounded wait for the serializer acknowledge (sel 0) or for lock (sel 1)
  task automatic wait_hi(input bit sel);
    for (int n = 0; n < 40 && (sel ? lock : done) !== 1'b1; n++)
      @(negedge clk);
    if ((sel ? lock : done) !== 1'b1)
    begin
      chk("wait", {7'h0, (sel ? lock : done)}, 8'h01);
      close_out();
    end
  endtask
  // One error pulse, then lock is compared; relock restores it
  task automatic err_hit(input logic [3:0] b, input logic e);
    @(negedge clk);
    errb = b;
    @(negedge clk);
    errb = 4'h0;
    repeat (3) @(negedge clk);
    chk("lock", {7'h0, lock}, {7'h0, e});
  endtask
  task automatic relock_go();
    @(negedge clk);
    relock = 1'b1;
    @(negedge clk);
    relock = 1'b0;
    wait_hi(1'b1);
  endtask
  // Scenarios
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    rd_reg(8'hb8, 8'h00, "strap early");
    repeat (12) @(negedge clk);
    rd_reg(8'hb8, 8'hda, "strap status");
    foreach (rst_tab[k]) rd_reg(rst_tab[k][15:8], rst_tab[k][7:0], "reset value");
    chk("crc enable", {7'h0, crc}, 8'h00);
    wr_reg(8'hb4, 8'hff);
    wr_reg(8'hb8, 8'hff);
    rd_reg(8'hb4, 8'h25, "reserved");
    rd_reg(8'hb8, 8'hda, "strap after write");
    rd_reg(8'h50, 8'h00, "unmapped");
    wr_reg(8'h4a, 8'h10);
    wr_reg(8'hba, 8'h00);
    rd_reg(8'hba, 8'h03, "encoder");
    chk("crc enable", {7'h0, crc}, 8'h01);
    wr_reg(8'hb3, 8'h05);
    wait_hi(1'b0);
    chk("test enable", {7'h0, ten}, 8'h01);
    chk("clock source", {6'h0, src}, 8'h02);
    chk("local config", {7'h0, tloc}, 8'h01);
    repeat (2) @(negedge clk);
    chk("mode none", {7'h0, tout}, 8'h00);
    wr_reg(8'hb3, 8'h45);
    v = tout;
    @(negedge clk);
    chk("mode alt", {7'h0, tout}, {7'h0, ~v});
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(8'hb3, k ? 8'hc5 : 8'h85);
      tdata = 1'b1;
      repeat (3) @(negedge clk);
      chk("mode data", {7'h0, tout}, 8'h01);
      tdata = 1'b0;
      repeat (3) @(negedge clk);
      chk("mode data", {7'h0, tout}, 8'h00);
    end
    wr_reg(8'hb3, 8'h00);
    slow = 1'b1;
    wr_reg(8'hb3, 8'h03);
    wait_hi(1'b0);
    chk("slow clock source", {6'h0, src}, 8'h01);
    wr_reg(8'hb9, 8'h31);
    for (int i = 0; i < 4; i++)
    begin
      err_hit(4'h1 << i, 1'b0);
      relock_go();
    end
    wr_reg(8'hb9, 8'h33);
    err_hit(4'h1, 1'b1);
    err_hit(4'h2, 1'b1);
    err_hit(4'h4, 1'b0);
    relock_go();
    wr_reg(8'hb9, 8'h23);
    err_hit(4'h8, 1'b0);
    relock_go();
    wr_reg(8'hb9, 8'h31);
    fwait = 1'b1;
    err_hit(4'h1, 1'b1);
    wr_reg(8'hb9, 8'h11);
    err_hit(4'h1, 1'b0);
    // Second reset with other strap levels: straps latch again, defaults return
    {idx_s, mode_s} = {3'h2, 3'h5};
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (12) @(negedge clk);
    rd_reg(8'hb8, 8'had, "strap after reset");
    rd_reg(8'hb3, 8'h08, "self test after reset");
    chk("default config", {7'h0, tloc}, 8'h00);
    chk("lock after reset", {7'h0, lock}, 8'h01);
    close_out();
  end
endmodule
